// >>> hdl/dts_pkg.sv
/*
 * constants, states and field layouts of the dma transfer sequencer.
 * assumes a single 250 mhz clock and a host that writes registers only while idle.
 */
// Overview of operation
// - final m2m write drops strobe, decrements count
// - count wrap ends service, else new read
// - first state latches address, checks request
// - second state acknowledges, drives read strobe
// - extended write strobe in state two or three
// - compressed timing skips the third state
// - native write strobe in state three
// - external end stops block or demand
// - third state waits while ready high
// - fourth state drops strobes, wrap ends service
// - continue at state two or one
// - fixed priority, channel zero highest
// - rotating priority puts served channel last
// - host register write and read decode
// - registers use the low data byte
// - requests pass a two flop synchroniser
// - request raises hold, waits for grant
// - single mode: one transfer per grant
// - block mode runs to terminal count unless ended externally or the request is gone at a page change
// - demand mode: request drop pauses in state four, ends in state three
// - m2m data held in temporary register
// - reset clears, idles and masks all
package dts_pkg;

    localparam int NCH = 4;
    localparam int AW = 16;
    localparam int WCW = 16;
    localparam int DW = 8;
    localparam int RAW = 4;

    // register indices on the host address bus
    localparam logic [3:0] REG_ADDR0 = 4'h0;   // addr ch n at 2n, count at 2n+1
    localparam logic [3:0] REG_CMD = 4'h8;
    localparam logic [3:0] REG_REQ = 4'h9;
    localparam logic [3:0] REG_MASK = 4'ha;
    localparam logic [3:0] REG_MODE = 4'hb;
    localparam logic [3:0] REG_FLIP = 4'hc;
    localparam logic [3:0] REG_STAT = 4'hd;
    localparam logic [3:0] REG_TEMP = 4'he;

    // command register fields
    localparam int CMD_M2M = 0;
    localparam int CMD_DIS = 2;
    localparam int CMD_COMP = 3;
    localparam int CMD_ROT = 4;
    localparam int CMD_EXTW = 5;

    // mode register fields: [1:0] channel, [3:2] direction, [4] auto, [5] down, [7:6] mode
    localparam int MODE_AUTO = 4;
    localparam int MODE_DOWN = 5;
    localparam logic [1:0] DIR_WRITE = 2'h1;   // io to memory
    localparam logic [1:0] XM_DEMAND = 2'h0;
    localparam logic [1:0] XM_SINGLE = 2'h1;
    localparam logic [1:0] XM_BLOCK = 2'h2;

    localparam logic [7:0] CMD_RST = 8'h00;
    localparam logic [NCH-1:0] MASK_RST = 4'hf;
    localparam logic [WCW-1:0] WC_ONES = 16'hffff;

    typedef enum logic [3:0] {
        DTS_IDLE,
        DTS_HOLD_WAIT,
        DTS_X1,
        DTS_X2,
        DTS_X3,
        DTS_X4,
        DTS_R1,
        DTS_R2,
        DTS_R3,
        DTS_R4,
        DTS_W1,
        DTS_W2,
        DTS_W3,
        DTS_W4
    } dts_state_t;

endpackage

// >>> hdl/dts_sequencer.sv
/*
 * dma transfer sequencer: arbitration, active-cycle state machine, host registers.
 * assumes an asynchronous active-low reset and asynchronous channel requests.
 */
`timescale 1ns/1ps
`default_nettype none
module dts_sequencer
(
    input wire logic clk_i,                        // 250 mhz clock
    input wire logic nrst_i,                       // async reset, active low
    input wire logic cs_n_i,                       // chip select
    input wire logic host_rd_n_i,                  // host register read
    input wire logic host_wr_n_i,                  // host register write
    input wire logic [dts_pkg::RAW-1:0] ain_i,     // register index
    input wire logic [dts_pkg::DW-1:0] dbin_i,     // host write data
    input wire logic [dts_pkg::NCH-1:0] dreq_i,    // async channel requests
    input wire logic hlda_i,                       // hold grant
    input wire logic ready_i,                      // wait extension
    input wire logic eopin_n_i,                    // external end of process
    output logic hreq_o,                           // hold request
    output logic aen_o,                            // address latch enable
    output logic [dts_pkg::AW-1:0] aout_o,         // transfer address
    output logic [dts_pkg::DW-1:0] dbout_o,        // read data / temp data
    output logic [dts_pkg::NCH-1:0] dack_o,        // acknowledges, active high
    output logic memr_n_o,                         // memory read strobe
    output logic memw_n_o,                         // memory write strobe
    output logic iorout_n_o,                       // io read strobe
    output logic iowout_n_o,                       // io write strobe
    output logic eopout_n_o                        // terminal count
);
    // ************************************************************
    // request synchroniser
    // ************************************************************
    logic [dts_pkg::NCH-1:0] rq_s1_q, rq_s2_q;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rq_s1_q <= '0;
            rq_s2_q <= '0;
        end
        else
        begin
            rq_s1_q <= dreq_i;
            rq_s2_q <= rq_s1_q;
        end
    end

    // ************************************************************
    // registers and state
    // ************************************************************
    logic [7:0] cmd_q, cmd_d;
    logic [dts_pkg::NCH-1:0] mask_q, mask_d, sreq_q, sreq_d, tc_q, tc_d;
    logic [7:0] mode_q [dts_pkg::NCH], mode_d [dts_pkg::NCH];
    logic [dts_pkg::AW-1:0] addr_q [dts_pkg::NCH], addr_d [dts_pkg::NCH];
    logic [dts_pkg::AW-1:0] base_a_q [dts_pkg::NCH], base_a_d [dts_pkg::NCH];
    logic [dts_pkg::WCW-1:0] wc_q [dts_pkg::NCH], wc_d [dts_pkg::NCH];
    logic [dts_pkg::WCW-1:0] base_w_q [dts_pkg::NCH], base_w_d [dts_pkg::NCH];
    logic [1:0] prio_q [dts_pkg::NCH], prio_d [dts_pkg::NCH];
    logic flip_q, flip_d;
    logic [7:0] temp_q, temp_d;
    logic [1:0] ch_q, ch_d;
    dts_pkg::dts_state_t st_q, st_d;
    logic [dts_pkg::DW-1:0] rd_q, rd_d;
    logic eop_q, eop_d;

    logic [dts_pkg::NCH-1:0] pend;
    logic any_pend, win_found;
    logic [1:0] win;
    logic m2m, wr;
    logic [1:0] xmode;

    assign m2m = cmd_q[dts_pkg::CMD_M2M];
    assign xmode = mode_q[ch_q][7:6];
    assign pend = (rq_s2_q | sreq_q) & ~mask_q;
    assign any_pend = (|pend) && !cmd_q[dts_pkg::CMD_DIS];
    assign wr = host_wr_n_i == 1'b0 && cs_n_i == 1'b0;

    always_comb
    begin
        logic [1:0] best;
        best = 2'h3;
        win = 2'h0;
        win_found = 1'b0;
        for (int i = 0; i < dts_pkg::NCH; i++)
        begin
            if (pend[i] && (!win_found || prio_q[i] < best))
            begin
                win = 2'(i);
                best = prio_q[i];
                win_found = 1'b1;
            end
        end
    end

    function automatic logic [dts_pkg::AW-1:0] step(input logic [dts_pkg::AW-1:0] a,
                                                  input logic down);
        step = down ? a - 16'h0001 : a + 16'h0001;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic [dts_pkg::WCW-1:0] nwc;
        logic wrap, ext_end, fin;
        nwc = wc_q[ch_q] - 16'h0001;
        wrap = wc_q[ch_q] == '0;
        ext_end = !eopin_n_i && xmode != dts_pkg::XM_SINGLE;
        fin = 1'b0;
        cmd_d = cmd_q;
        mask_d = mask_q;
        sreq_d = sreq_q;
        tc_d = tc_q;
        mode_d = mode_q;
        addr_d = addr_q;
        base_a_d = base_a_q;
        wc_d = wc_q;
        base_w_d = base_w_q;
        prio_d = prio_q;
        flip_d = flip_q;
        temp_d = temp_q;
        ch_d = ch_q;
        st_d = st_q;
        eop_d = 1'b0;
        rd_d = '0;
        if (wr)
        begin
            case (ain_i)
                dts_pkg::REG_CMD: cmd_d = dbin_i[7:0];
                dts_pkg::REG_REQ: sreq_d[dbin_i[1:0]] = dbin_i[2];
                dts_pkg::REG_MASK: mask_d[dbin_i[1:0]] = dbin_i[2];
                dts_pkg::REG_MODE: mode_d[dbin_i[1:0]] = dbin_i[7:0];
                dts_pkg::REG_FLIP: flip_d = 1'b0;
                default:
                begin
                    if (ain_i < dts_pkg::REG_CMD)
                    begin
                        flip_d = !flip_q;
                        if (!ain_i[0])
                        begin
                            if (flip_q) addr_d[ain_i[2:1]][15:8] = dbin_i[7:0];
                            else addr_d[ain_i[2:1]][7:0] = dbin_i[7:0];
                            base_a_d[ain_i[2:1]] = addr_d[ain_i[2:1]];
                        end
                        else
                        begin
                            if (flip_q) wc_d[ain_i[2:1]][15:8] = dbin_i[7:0];
                            else wc_d[ain_i[2:1]][7:0] = dbin_i[7:0];
                            base_w_d[ain_i[2:1]] = wc_d[ain_i[2:1]];
                        end
                    end
                end
            endcase
        end
        if (!cs_n_i && !host_rd_n_i)
        begin
            case (ain_i)
                dts_pkg::REG_STAT: rd_d = {4'h0, tc_q};
                dts_pkg::REG_TEMP: rd_d = temp_q;
                dts_pkg::REG_MASK: rd_d = {4'h0, mask_q};
                default: rd_d = ain_i[0] ? wc_q[ain_i[2:1]][7:0] : addr_q[ain_i[2:1]][7:0];
            endcase
        end
        case (st_q)
            dts_pkg::DTS_IDLE:
                if (any_pend)
                begin
                    ch_d = m2m ? 2'h0 : win;
                    st_d = dts_pkg::DTS_HOLD_WAIT;
                end
            dts_pkg::DTS_HOLD_WAIT:
                if (hlda_i)
                    st_d = m2m ? dts_pkg::DTS_R1 : dts_pkg::DTS_X1;
            dts_pkg::DTS_X1:
                st_d = pend[ch_q] ? dts_pkg::DTS_X2 : dts_pkg::DTS_IDLE;
            dts_pkg::DTS_X2:
                if (ext_end) fin = 1'b1;
                else if (cmd_q[dts_pkg::CMD_COMP]) st_d = dts_pkg::DTS_X4;
                else st_d = dts_pkg::DTS_X3;
            dts_pkg::DTS_X3:
                if (ext_end || (xmode == dts_pkg::XM_DEMAND && !pend[ch_q])) fin = 1'b1;
                else if (!ready_i) st_d = dts_pkg::DTS_X4;
            dts_pkg::DTS_X4:
            begin
                wc_d[ch_q] = nwc;
                addr_d[ch_q] = step(addr_q[ch_q], mode_q[ch_q][dts_pkg::MODE_DOWN]);
                if (wrap)
                begin
                    eop_d = 1'b1;
                    fin = 1'b1;
                end
                else if (ext_end || xmode == dts_pkg::XM_SINGLE
                         || (xmode == dts_pkg::XM_DEMAND && !pend[ch_q]))
                    st_d = dts_pkg::DTS_IDLE;
                else if (addr_d[ch_q][15:8] == addr_q[ch_q][15:8]) st_d = dts_pkg::DTS_X2;
                else st_d = dts_pkg::DTS_X1;
            end
            dts_pkg::DTS_R1: st_d = dts_pkg::DTS_R2;
            dts_pkg::DTS_R2: st_d = dts_pkg::DTS_R3;
            dts_pkg::DTS_R3: if (!ready_i) st_d = dts_pkg::DTS_R4;
            dts_pkg::DTS_R4:
            begin
                temp_d = dbin_i[7:0];
                addr_d[0] = step(addr_q[0], mode_q[0][dts_pkg::MODE_DOWN]);
                st_d = dts_pkg::DTS_W1;
            end
            dts_pkg::DTS_W1: st_d = dts_pkg::DTS_W2;
            dts_pkg::DTS_W2: st_d = dts_pkg::DTS_W3;
            dts_pkg::DTS_W3: if (!ready_i) st_d = dts_pkg::DTS_W4;
            dts_pkg::DTS_W4:
            begin
                wc_d[1] = wc_q[1] - 16'h0001;
                addr_d[1] = step(addr_q[1], mode_q[1][dts_pkg::MODE_DOWN]);
                if (wc_q[1] == '0)
                begin
                    eop_d = 1'b1;
                    fin = 1'b1;
                end
                else st_d = dts_pkg::DTS_R1;
            end
            default: st_d = dts_pkg::DTS_IDLE;
        endcase
        if (fin)
        begin
            st_d = dts_pkg::DTS_IDLE;
            tc_d[ch_q] = 1'b1;
            sreq_d[ch_q] = 1'b0;
            if (mode_q[ch_q][dts_pkg::MODE_AUTO])
            begin
                addr_d[ch_q] = base_a_q[ch_q];
                wc_d[ch_q] = base_w_q[ch_q];
            end
            else mask_d[ch_q] = 1'b1;
        end
        if (st_q == dts_pkg::DTS_X4 && st_d != dts_pkg::DTS_X2 && cmd_q[dts_pkg::CMD_ROT])
            for (int i = 0; i < dts_pkg::NCH; i++)
                prio_d[i] = (i == ch_q) ? 2'h3 : (prio_q[i] > prio_q[ch_q] ? prio_q[i] - 2'h1
                                                                           : prio_q[i]);
    end

    // ************************************************************
    // registers
    // ************************************************************
    // reset clears and masks
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cmd_q <= dts_pkg::CMD_RST;
            mask_q <= dts_pkg::MASK_RST;
            sreq_q <= '0;
            tc_q <= '0;
            flip_q <= 1'b0;
            temp_q <= '0;
            ch_q <= '0;
            st_q <= dts_pkg::DTS_IDLE;
            rd_q <= '0;
            eop_q <= 1'b0;
            for (int i = 0; i < dts_pkg::NCH; i++)
            begin
                mode_q[i] <= '0;
                addr_q[i] <= '0;
                base_a_q[i] <= '0;
                wc_q[i] <= '0;
                base_w_q[i] <= '0;
                prio_q[i] <= 2'(i);
            end
        end
        else
        begin
            cmd_q <= cmd_d;
            mask_q <= mask_d;
            sreq_q <= sreq_d;
            tc_q <= tc_d;
            flip_q <= flip_d;
            temp_q <= temp_d;
            ch_q <= ch_d;
            st_q <= st_d;
            rd_q <= rd_d;
            eop_q <= eop_d;
            mode_q <= mode_d;
            addr_q <= addr_d;
            base_a_q <= base_a_d;
            wc_q <= wc_d;
            base_w_q <= base_w_d;
            prio_q <= prio_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic x_act, rd_ph, wr_ph, io_wr, m_any, w_ph;
    assign x_act = st_q == dts_pkg::DTS_X2 || st_q == dts_pkg::DTS_X3
                   || st_q == dts_pkg::DTS_X4;
    assign m_any = st_q inside {dts_pkg::DTS_R1, dts_pkg::DTS_R2, dts_pkg::DTS_R3,
                                dts_pkg::DTS_R4, dts_pkg::DTS_W1, dts_pkg::DTS_W2,
                                dts_pkg::DTS_W3, dts_pkg::DTS_W4};
    assign io_wr = mode_q[ch_q][3:2] == dts_pkg::DIR_WRITE;
    // read strobe in states two and three
    assign rd_ph = st_q == dts_pkg::DTS_X2 || st_q == dts_pkg::DTS_X3;
    assign w_ph = st_q == dts_pkg::DTS_X3
                  || (st_q == dts_pkg::DTS_X2 && cmd_q[dts_pkg::CMD_EXTW]);
    assign wr_ph = w_ph;
    assign hreq_o = st_q != dts_pkg::DTS_IDLE;
    assign aen_o = x_act || st_q == dts_pkg::DTS_X1 || m_any;
    assign aout_o = st_q inside {dts_pkg::DTS_W1, dts_pkg::DTS_W2, dts_pkg::DTS_W3,
                                 dts_pkg::DTS_W4} ? addr_q[1] : addr_q[ch_q];
    assign dack_o = x_act ? (dts_pkg::NCH)'(1) << ch_q : '0;
    assign memr_n_o = !((rd_ph && io_wr == 1'b0) || st_q == dts_pkg::DTS_R2
                        || st_q == dts_pkg::DTS_R3);
    assign iorout_n_o = !(rd_ph && io_wr);
    assign memw_n_o = !((wr_ph && io_wr) || st_q == dts_pkg::DTS_W3);
    assign iowout_n_o = !(wr_ph && !io_wr);
    assign eopout_n_o = !eop_q;
    // temp drives data in write phase
    assign dbout_o = st_q == dts_pkg::DTS_W3 ? temp_q : rd_q;

    // ************************************************************
    // checks
    // ************************************************************
    AST_HOLD_WAIT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_HOLD_WAIT && !hlda_i |=> st_q == dts_pkg::DTS_HOLD_WAIT)
        else $error("left hold wait without grant");
    AST_X1_ALE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_X1 |-> aen_o && dack_o == '0)
        else $error("state one outputs wrong");
    AST_X2_ACK: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_X2 |-> dack_o[ch_q] && !(memr_n_o && iorout_n_o))
        else $error("state two missing ack or read");
    AST_X3_READY: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_X3 && ready_i && eopin_n_i && xmode != dts_pkg::XM_DEMAND
        |=> st_q == dts_pkg::DTS_X3)
        else $error("left state three while ready");
    AST_COMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_X2 && cmd_q[dts_pkg::CMD_COMP] && eopin_n_i
        |=> st_q == dts_pkg::DTS_X4)
        else $error("compressed timing did not skip");
    AST_X4_STROBE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_X4 |-> memr_n_o && memw_n_o && iorout_n_o && iowout_n_o)
        else $error("strobe active in state four");
    AST_TC: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_W4 && wc_q[1] == '0
        |=> !eopout_n_o && st_q == dts_pkg::DTS_IDLE)
        else $error("no terminal count on wrap");
    AST_W4_DEC: assert property (@(posedge clk_i) disable iff (!nrst_i)
        st_q == dts_pkg::DTS_W4 && wc_q[1] != '0
        |=> wc_q[1] == $past(wc_q[1]) - 16'h0001 && memw_n_o)
        else $error("m2m count not decremented");
    AST_SYNC: assert property (@(posedge clk_i) disable iff (!nrst_i)
        rq_s2_q == $past(rq_s1_q))
        else $error("sync stage mismatch");
    COV_IO: cover property (@(posedge clk_i) st_q == dts_pkg::DTS_X4 ##1 st_q == dts_pkg::DTS_X2);
    COV_M2M: cover property (@(posedge clk_i) st_q == dts_pkg::DTS_W4 ##1 !eopout_n_o);
    COV_WAIT: cover property (@(posedge clk_i) st_q == dts_pkg::DTS_X3 [*3]);
endmodule
`default_nettype wire

// >>> testbench/dts_far_end.sv
/*
 * far side model: peripherals raising requests and an arbiter granting hold.
 * assumes active-high acknowledges and hold request from the sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
module dts_far_end
(
    input wire logic clk_i,                        // clock
    input wire logic nrst_i,                       // reset, active low
    input wire logic [dts_pkg::NCH-1:0] want_i,    // service wanted, pulse
    input wire logic [3:0] gnt_dly_i,              // grant latency
    input wire logic hreq_i,                       // hold request
    input wire logic [dts_pkg::NCH-1:0] dack_i,    // acknowledges
    output logic [dts_pkg::NCH-1:0] dreq_o,        // channel requests
    output logic hlda_o                            // hold grant
);
    logic [3:0] wait_q;
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            dreq_o <= '0;
            hlda_o <= 1'b0;
            wait_q <= 4'h0;
        end
        else
        begin
            dreq_o <= (dreq_o | want_i) & ~dack_i;
            // grant withdrawn as soon as hold is dropped, never early
            if (!hreq_i)
            begin
                hlda_o <= 1'b0;
                wait_q <= 4'h0;
            end
            else if (wait_q >= gnt_dly_i)
                hlda_o <= 1'b1;
            else
                wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
/*
 * self-checking bench for the transfer sequencer with a far side model.
 * assumes the register map and bit fields of the sequencer package.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, nrst, cs_n, rd_n, wr_n, hlda, ready, eopin_n, ior_q, mw_q;
    logic hreq, aen, memr_n, memw_n, iorout_n, iowout_n, eopout_n;
    logic [3:0] ain, dreq, dack, want, gnt_dly;
    logic [7:0] dbin, dbout;
    logic [15:0] aout;
    logic [31:0] rnd, rdy_rnd;
    logic [19:0] expq[$];
    int fail_count, num_checks, tc_seen, exp_tc;

    dts_sequencer DUT (.clk_i(clk), .nrst_i(nrst), .cs_n_i(cs_n), .host_rd_n_i(rd_n),
        .host_wr_n_i(wr_n), .ain_i(ain), .dbin_i(dbin), .dreq_i(dreq), .hlda_i(hlda),
        .ready_i(ready), .eopin_n_i(eopin_n), .hreq_o(hreq), .aen_o(aen), .aout_o(aout),
        .dbout_o(dbout), .dack_o(dack), .memr_n_o(memr_n), .memw_n_o(memw_n),
        .iorout_n_o(iorout_n), .iowout_n_o(iowout_n), .eopout_n_o(eopout_n));
    dts_far_end far (.clk_i(clk), .nrst_i(nrst), .want_i(want), .gnt_dly_i(gnt_dly),
        .hreq_i(hreq), .dack_i(dack), .dreq_o(dreq), .hlda_o(hlda));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    always #2 clk = ~clk;

    task chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ****************************************
    // host and service helpers
    // ****************************************
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        ain <= a;
        dbin <= d;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
    endtask

    task prog(input int ch, input logic [7:0] mode, input logic [15:0] a, input logic [15:0] n);
        wr(dts_pkg::REG_FLIP, 8'h00);
        wr(4'(2 * ch), a[7:0]);
        wr(4'(2 * ch), a[15:8]);
        wr(4'(2 * ch + 1), n[7:0]);
        wr(4'(2 * ch + 1), n[15:8]);
        wr(dts_pkg::REG_MODE, mode);
        wr(dts_pkg::REG_MASK, 8'(ch));
    endtask

    task serve(input logic [3:0] w);
        int n;
        rnd = lfsr(rnd);
        gnt_dly <= {1'b0, rnd[2:0]};
        want <= w;
        @(posedge clk);
        want <= 4'h0;
        n = 0;
        while ((expq.size() != 0 || hreq !== 1'b0) && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        chk("service end", 20'(n >= 3000), 20'h0);
    endtask

    // each new io read strobe, or m2m write strobe, is one transfer: acknowledge and address
    always @(posedge clk)
    begin
        rdy_rnd = lfsr(rdy_rnd);
        ready <= rdy_rnd[0] & rdy_rnd[1];
        if (ior_q === 1'b1 && iorout_n === 1'b0)
            chk("transfer", {dack, aout}, expq.size() ? expq.pop_front() : 20'h0);
        if (mw_q === 1'b1 && memw_n === 1'b0 && dack === 4'h0)
        begin
            chk("m2m write", {dack, aout}, expq.size() ? expq.pop_front() : 20'h0);
            chk("temp data", 20'(dbout), 20'(dbin));
        end
        if (eopout_n === 1'b0)
            tc_seen++;
        ior_q <= iorout_n;
        mw_q <= memw_n;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        logic [7:0] cmds[4];
        logic [15:0] a0, a2;
        cmds = '{8'h00, 8'h08, 8'h10, 8'h20};
        {clk, nrst, cs_n, rd_n, wr_n, eopin_n} = 6'b001111;
        {ain, dbin, want, gnt_dly} = '0;
        rnd = 32'hfd6c;
        rdy_rnd = 32'hfd6c;
        repeat (5) @(posedge clk);
        chk("reset", {hreq, aen, dack, memr_n, memw_n, iorout_n, iowout_n, eopout_n}, 20'h1f);
        nrst <= 1'b1;
        want <= 4'h8;
        @(posedge clk);
        want <= 4'h0;
        repeat (12) @(posedge clk);
        chk("masked request", 20'(hreq), 20'h0);
        // two single transfers contend; channel 0 wins
        wr(dts_pkg::REG_CMD, 8'h00);
        rnd = lfsr(rnd);
        a0 = rnd[15:0];
        a2 = rnd[31:16];
        prog(0, 8'h44, a0, 16'h0000);
        prog(2, 8'h46, a2, 16'h0000);
        expq.push_back({4'h1, a0});
        expq.push_back({4'h4, a2});
        exp_tc += 2;
        serve(4'h5);
        // block of three under each command option, last one counting down
        foreach (cmds[i])
        begin
            wr(dts_pkg::REG_CMD, cmds[i]);
            rnd = lfsr(rnd);
            // mid-page start: the released request would stop a latch reload
            a0 = {rnd[15:8], 8'h80};
            prog(1, (i == 3) ? 8'ha5 : 8'h85, a0, 16'h0002);
            for (int k = 0; k < 3; k++)
                expq.push_back({4'h2, (i == 3) ? a0 - 16'(k) : a0 + 16'(k)});
            exp_tc++;
            serve(4'h2);
        end
        // memory to memory, channel 0 to channel 1, one word
        wr(dts_pkg::REG_CMD, 8'h01);
        rnd = lfsr(rnd);
        prog(0, 8'h88, rnd[15:0], 16'h0000);
        prog(1, 8'h85, rnd[31:16], 16'h0000);
        expq.push_back({4'h0, rnd[31:16]});
        exp_tc++;
        wr(dts_pkg::REG_REQ, 8'h04);
        serve(4'h0);
        repeat (4) @(posedge clk);
        chk("terminal counts", 20'(tc_seen), 20'(exp_tc));
        finish_test();
    end

    initial
    begin
        repeat (30000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
